// ==== design/port_pin_pkg.sv ====
package port_pin_pkg;
  // register word addresses (Avalon word index, compared directly with address)
  localparam logic [3:0] ADDR_PAD_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_PORT_A_PIN = 4'h1;
  localparam logic [3:0] ADDR_PORT_A_LAT = 4'h2;
  localparam logic [3:0] ADDR_PORT_A_DIR = 4'h3;
  localparam logic [3:0] ADDR_ANALOG_SEL = 4'h4;
  localparam logic [3:0] ADDR_PORT_C_PIN = 4'h5;
  localparam logic [3:0] ADDR_PORT_C_LAT = 4'h6;
  localparam logic [3:0] ADDR_PORT_C_DIR = 4'h7;
  localparam logic [3:0] ADDR_OPEN_DRAIN = 4'h8;
  localparam logic [3:0] ADDR_RTC_CTRL = 4'h9;
  // pad_config fields
  localparam int PAD_D_PU_BIT = 7;
  localparam int PAD_E_PU_BIT = 6;
  localparam int PAD_J_PU_BIT = 5;
  localparam int PAD_SEL_HI = 2;
  localparam int PAD_SEL_LO = 1;
  localparam logic [7:0] PAD_CONFIG_MASK = 8'he6;
  // open-drain control fields
  localparam int OD_CAP1_BIT = 0;
  localparam int OD_CAP2_BIT = 1;
  localparam int OD_SPI_BIT = 2;
  localparam int OD_UART_BIT = 3;
  localparam logic [7:0] OPEN_DRAIN_MASK = 8'h0f;
  // rtc control field
  localparam int RTC_OE_BIT = 0;
  // rtc output select codes
  localparam logic [1:0] RTC_SEL_SRC = 2'h2;
  localparam logic [1:0] RTC_SEL_SEC = 2'h1;
  localparam logic [1:0] RTC_SEL_ALARM = 2'h0;
  // reset values
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [7:0] ANALOG_RESET = 8'hff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // oscillator-shared and special pins of port a
  localparam int OSC_OUT_BIT = 6;
  localparam int OSC_IN_BIT = 7;
  localparam int T0_PIN_BIT = 4;
  localparam int T1_PIN_BIT = 5;
  // port c pin roles
  localparam int SEC_CLK_BIT = 0;
  localparam int CHAN2_BIT = 1;
  localparam int CHAN1_BIT = 2;
  localparam int SPI_BIT = 5;
  localparam int UART_BIT = 6;
  // cycle clock divider
  localparam int CYCLE_DIV = 4;
  localparam logic [1:0] CYCLE_HALF = 2'h1;
endpackage : port_pin_pkg

// ==== design/pin_cell.sv ====
`timescale 1ns/100ps
// one pad: output mux, open-drain, input gate; all outputs registered
module pin_cell
  import port_pin_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // port controls
  input wire logic dir_in,
  input wire logic lat_in,
  input wire logic disable_in,
  input wire logic analog_in,
  // peripheral override
  input wire logic periph_act,
  input wire logic periph_val,
  input wire logic periph_tri,
  input wire logic open_drain,
  // pad
  input wire logic pad_i,
  output logic pad_o,
  output logic pad_oe,
  output logic level_reg
);
  // drive value and enable before registering
  wire drive_val = periph_act ? periph_val : lat_in;
  wire drive_on = !dir_in && !disable_in && !(periph_act && periph_tri);
  wire oe_next = drive_on && !(open_drain && periph_act && drive_val);
  // an input pin reads low while analog or claimed, so no toggling through buffer
  wire level_next = pad_i && !analog_in && !disable_in;

  // pad registers; reset itself clears oe so pins come up as inputs
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pad_o <= 1'b0;
      pad_oe <= 1'b0;
      level_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      pad_o <= drive_val;
      pad_oe <= oe_next;
      level_reg <= level_next;
    end
  end
endmodule : pin_cell

// ==== design/port_pin_control.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// - pull-up group bits gate latch-driven pull-ups
// - select code routes rtc source to pin
// - rtc pin driven only with enable set
// - direction 0 drives latch, analog ignored
// - direction 1 reads pin, analog blocks
// - analog select resets to analog
// - timer-zero pin resets digital input
// - oscillator claim disables two port bits
// - claimed bits read as undefined
// - claimed output pin carries clock div four
// - timer inputs bypass direction bit
// - port c eight bidirectional bits
// - any reset makes port c inputs
// - direction read returns stored value
// - active compare/pwm output beats latch
// - open-drain when bit set and active
// - channel two on bit one when assigned
// - secondary clock input only oscillator off
// - pwm channel a tri-states on shutdown
module port_pin_control
  import port_pin_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // configuration straps
  input wire logic osc_pin_claim_cfg,
  input wire logic chan2_pin_assign_cfg,
  input wire logic secondary_oscillator,
  // port a pads
  input wire logic [7:0] port_a_i,
  output logic [7:0] port_a_o,
  output logic [7:0] port_a_oe,
  // port c pads
  input wire logic [7:0] port_c_i,
  output logic [7:0] port_c_o,
  output logic [7:0] port_c_oe,
  // pull-up enables per group
  input wire logic [7:0] port_d_latch,
  input wire logic [7:0] port_e_latch,
  input wire logic [7:0] port_j_latch,
  output logic [7:0] group_d_pullup_en,
  output logic [7:0] group_e_pullup_en,
  output logic [7:0] group_j_pullup_en,
  // real-time clock sources and pin
  input wire logic rtc_src_clk,
  input wire logic rtc_sec_clk,
  input wire logic rtc_alarm,
  output logic real_time_clock,
  output logic real_time_clock_oe,
  // peripheral outputs on port c
  input wire logic chan1_pwm_out_a,
  input wire logic chan1_act,
  input wire logic chan1_shutdown_tri,
  input wire logic chan2_pwm_out_a,
  input wire logic chan2_act,
  input wire logic chan2_shutdown_tri,
  input wire logic spi_out,
  input wire logic spi_act,
  input wire logic uart_out,
  input wire logic uart_act,
  // peripheral inputs
  output logic timer_zero_clk_in,
  output logic timer_one_clk_in,
  output logic timer_three_gate_in,
  output logic secondary_digital_clk_in,
  output logic enh_capture_chan2
);
  // software registers
  logic [7:0] pad_config_reg;
  logic [7:0] port_a_output_latch_reg;
  logic [7:0] port_a_direction_reg;
  logic [7:0] analog_select_low_reg;
  logic [7:0] port_c_output_latch_reg;
  logic [7:0] port_c_direction_reg;
  logic [7:0] open_drain_ctrl_reg;
  logic rtc_out_enable_reg;
  logic [1:0] cyc_cnt_reg;
  logic cycle_clock_out_reg;
  logic ack_reg;
  logic [7:0] port_a_level;
  logic [7:0] port_c_level;

  // bus decode
  wire rd_ack = read && !ack_reg;
  // a write lands only on the edge at which the master sees waitrequest low
  wire wr_ack = write && ack_reg;
  wire sel_pad = address == ADDR_PAD_CONFIG;
  // port and latch addresses share the latch, pin address only on read
  wire sel_a_lat = (address == ADDR_PORT_A_PIN) || (address == ADDR_PORT_A_LAT);
  wire sel_a_dir = address == ADDR_PORT_A_DIR;
  wire sel_an = address == ADDR_ANALOG_SEL;
  wire sel_c_lat = (address == ADDR_PORT_C_PIN) || (address == ADDR_PORT_C_LAT);
  wire sel_c_dir = address == ADDR_PORT_C_DIR;
  wire sel_od = address == ADDR_OPEN_DRAIN;
  wire sel_rtc = address == ADDR_RTC_CTRL;
  wire [7:0] wbyte = writedata[7:0];
  // claimed bits disabled: mask for reads of port a registers
  wire [7:0] osc_pin_bits = (8'h01 << OSC_OUT_BIT) | (8'h01 << OSC_IN_BIT);
  wire [7:0] claim_mask = osc_pin_claim_cfg ? ~osc_pin_bits : 8'hff;

  // read mux; claimed bits read 0, which is one legal undefined value
  logic [7:0] rd_byte;
  always_comb
  begin
    unique case (address)
      ADDR_PAD_CONFIG: rd_byte = pad_config_reg;
      ADDR_PORT_A_PIN: rd_byte = port_a_level & claim_mask;
      ADDR_PORT_A_LAT: rd_byte = port_a_output_latch_reg & claim_mask;
      ADDR_PORT_A_DIR: rd_byte = port_a_direction_reg & claim_mask;
      ADDR_ANALOG_SEL: rd_byte = analog_select_low_reg;
      ADDR_PORT_C_PIN: rd_byte = port_c_level;
      ADDR_PORT_C_LAT: rd_byte = port_c_output_latch_reg;
      ADDR_PORT_C_DIR: rd_byte = port_c_direction_reg;
      ADDR_OPEN_DRAIN: rd_byte = open_drain_ctrl_reg;
      ADDR_RTC_CTRL: rd_byte = {7'h00, rtc_out_enable_reg};
      default: rd_byte = ZERO_BYTE; // unmapped reads zero
    endcase
  end

  // one wait cycle per access, then ack; writes land on the ack edge
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ack_reg <= 1'b0;
    else if (clk_en)
      ack_reg <= (read || write) && !ack_reg;
  end

  // waitrequest is the inverse of ack_reg from its own flop, so the bus never sees a decode glitch
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      waitrequest <= 1'b1;
    else if (clk_en)
      waitrequest <= !((read || write) && !ack_reg);
  end

  // read data register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      readdata <= 32'h0000_0000;
    else if (clk_en && rd_ack)
      readdata <= {24'h000000, rd_byte};
  end

  // writable registers; reset: all pins input, analog selected
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pad_config_reg <= ZERO_BYTE;
      port_a_output_latch_reg <= ZERO_BYTE;
      port_a_direction_reg <= DIR_RESET;
      analog_select_low_reg <= ANALOG_RESET;
      port_c_output_latch_reg <= ZERO_BYTE;
      port_c_direction_reg <= DIR_RESET;
      open_drain_ctrl_reg <= ZERO_BYTE;
      rtc_out_enable_reg <= 1'b0;
    end
    else if (clk_en && wr_ack)
    begin
      if (sel_pad)
        pad_config_reg <= wbyte & PAD_CONFIG_MASK;
      if (sel_a_lat)
        port_a_output_latch_reg <= wbyte;
      if (sel_a_dir)
        port_a_direction_reg <= wbyte;
      if (sel_an)
        analog_select_low_reg <= wbyte;
      if (sel_c_lat)
        port_c_output_latch_reg <= wbyte;
      if (sel_c_dir)
        port_c_direction_reg <= wbyte;
      if (sel_od)
        open_drain_ctrl_reg <= wbyte & OPEN_DRAIN_MASK;
      if (sel_rtc)
        rtc_out_enable_reg <= wbyte[RTC_OE_BIT];
    end
  end

  // cycle clock divide-by-four for the claimed output pin
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cyc_cnt_reg <= 2'h0;
      cycle_clock_out_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      cyc_cnt_reg <= cyc_cnt_reg + 2'h1;
      if (cyc_cnt_reg == CYCLE_HALF || cyc_cnt_reg == 2'(CYCLE_DIV - 1))
        cycle_clock_out_reg <= !cycle_clock_out_reg;
    end
  end

  // port a: analog pins are 0..3 and 5..7; pin 4 has none
  wire [7:0] a_analog = analog_select_low_reg & ~(8'h01 << T0_PIN_BIT);
  // the input pin is cut off; the output pin takes the cycle clock as an override
  wire [7:0] a_disable = osc_pin_claim_cfg ? (8'h01 << OSC_IN_BIT) : ZERO_BYTE;
  wire [7:0] a_clk_act = osc_pin_claim_cfg ? (8'h01 << OSC_OUT_BIT) : ZERO_BYTE;
  wire [7:0] a_dir = port_a_direction_reg & ~a_clk_act;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_port_a
      pin_cell u_cell (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .dir_in(a_dir[gi]),
        .lat_in(port_a_output_latch_reg[gi]),
        .disable_in(a_disable[gi]),
        .analog_in(a_analog[gi]),
        .periph_act(a_clk_act[gi]),
        .periph_val(cycle_clock_out_reg),
        .periph_tri(1'b0),
        .open_drain(1'b0),
        .pad_i(port_a_i[gi]),
        .pad_o(port_a_o[gi]),
        .pad_oe(port_a_oe[gi]),
        .level_reg(port_a_level[gi])
      );
    end
  endgenerate

  // port c peripheral overrides, per pin
  wire chan2_on = chan2_act && chan2_pin_assign_cfg;
  wire [7:0] c_act = {1'b0, uart_act, spi_act, 3'h0, chan2_on, 1'b0} |
    ({7'h00, chan1_act} << CHAN1_BIT);
  wire [7:0] c_val = ({7'h00, uart_out} << UART_BIT) | ({7'h00, spi_out} << SPI_BIT) |
    ({7'h00, chan1_pwm_out_a} << CHAN1_BIT) | ({7'h00, chan2_pwm_out_a} << CHAN2_BIT);
  wire [7:0] c_tri = ({7'h00, chan1_shutdown_tri} << CHAN1_BIT) |
    ({7'h00, chan2_shutdown_tri} << CHAN2_BIT);
  wire [7:0] c_od = ({7'h00, open_drain_ctrl_reg[OD_UART_BIT]} << UART_BIT) |
    ({7'h00, open_drain_ctrl_reg[OD_SPI_BIT]} << SPI_BIT) |
    ({7'h00, open_drain_ctrl_reg[OD_CAP1_BIT]} << CHAN1_BIT) |
    ({7'h00, open_drain_ctrl_reg[OD_CAP2_BIT]} << CHAN2_BIT);
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_port_c
      pin_cell u_cell (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .dir_in(port_c_direction_reg[gi]),
        .lat_in(port_c_output_latch_reg[gi]),
        .disable_in(1'b0),
        .analog_in(1'b0),
        .periph_act(c_act[gi]),
        .periph_val(c_val[gi]),
        .periph_tri(c_tri[gi]),
        .open_drain(c_od[gi]),
        .pad_i(port_c_i[gi]),
        .pad_o(port_c_o[gi]),
        .pad_oe(port_c_oe[gi]),
        .level_reg(port_c_level[gi])
      );
    end
  endgenerate

  // rtc pin source select; reserved code gives low
  wire rtc_sel_val = (pad_config_reg[PAD_SEL_HI:PAD_SEL_LO] == RTC_SEL_SRC) ? rtc_src_clk :
    (pad_config_reg[PAD_SEL_HI:PAD_SEL_LO] == RTC_SEL_SEC) ? rtc_sec_clk :
    (pad_config_reg[PAD_SEL_HI:PAD_SEL_LO] == RTC_SEL_ALARM) ? rtc_alarm : 1'b0;

  // registered side outputs: pull-ups, rtc pin, peripheral inputs
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      group_d_pullup_en <= ZERO_BYTE;
      group_e_pullup_en <= ZERO_BYTE;
      group_j_pullup_en <= ZERO_BYTE;
      real_time_clock <= 1'b0;
      real_time_clock_oe <= 1'b0;
      timer_zero_clk_in <= 1'b0;
      timer_one_clk_in <= 1'b0;
      timer_three_gate_in <= 1'b0;
      secondary_digital_clk_in <= 1'b0;
      enh_capture_chan2 <= 1'b0;
    end
    else if (clk_en)
    begin
      group_d_pullup_en <= port_d_latch & {8{pad_config_reg[PAD_D_PU_BIT]}};
      group_e_pullup_en <= port_e_latch & {8{pad_config_reg[PAD_E_PU_BIT]}};
      group_j_pullup_en <= port_j_latch & {8{pad_config_reg[PAD_J_PU_BIT]}};
      real_time_clock <= rtc_sel_val & rtc_out_enable_reg;
      real_time_clock_oe <= rtc_out_enable_reg;
      timer_zero_clk_in <= port_a_i[T0_PIN_BIT];
      timer_one_clk_in <= port_a_i[T1_PIN_BIT];
      timer_three_gate_in <= port_a_i[T1_PIN_BIT];
      secondary_digital_clk_in <= port_c_i[SEC_CLK_BIT] & !secondary_oscillator;
      enh_capture_chan2 <= port_c_i[CHAN2_BIT] & chan2_pin_assign_cfg;
    end
  end

  // rtc pin stays released while its enable is clear
  a_rtc_oe_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && !rtc_out_enable_reg) |=> !real_time_clock_oe && !real_time_clock)
    else $error("rtc pin driven without enable");

  // direction read returns stored value
  a_dir_read_back: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && rd_ack && address == ADDR_PORT_C_DIR) |=>
      readdata[7:0] == $past(port_c_direction_reg))
    else $error("direction read mismatch");

  // group d pull-ups off when its group bit clear
  a_pullup_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && !pad_config_reg[PAD_D_PU_BIT]) |=> group_d_pullup_en == ZERO_BYTE)
    else $error("pull-up active with group off");

  // a request seen while waitrequest is high is the one being taken
  sequence s_bus_taken;
    clk_en && (read || write) && waitrequest;
  endsequence

  a_wait_one_cycle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_bus_taken |=> !waitrequest)
    else $error("request not answered after one wait cycle");

  // the answer stands for one cycle only
  a_ack_one_cycle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && !waitrequest) |=> waitrequest)
    else $error("waitrequest low for more than one cycle");

  // claimed output pin is always driven
  a_claim_drives: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && osc_pin_claim_cfg) |=> port_a_oe[OSC_OUT_BIT])
    else $error("claimed pin not driven");

  // open-drain channel one never drives a high
  a_od_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && open_drain_ctrl_reg[OD_CAP1_BIT] && chan1_act && chan1_pwm_out_a) |=>
      !port_c_oe[CHAN1_BIT])
    else $error("open-drain pin drove high");

  // shutdown tri-state releases channel one
  a_pwm_tristate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && chan1_act && chan1_shutdown_tri) |=> !port_c_oe[CHAN1_BIT])
    else $error("pwm pin driven during shutdown");
endmodule : port_pin_control

// ==== dv/pad_board_model.sv ====
`timescale 1ns/100ps
// board side of both ports; a pad the device drives reads back its own level
module pad_board_model (
  // device pads
  input wire logic [7:0] port_a_o,
  input wire logic [7:0] port_a_oe,
  input wire logic [7:0] port_c_o,
  input wire logic [7:0] port_c_oe,
  // board levels
  input wire logic [7:0] ext_a,
  input wire logic [7:0] ext_c,
  // resolved pad levels
  output logic [7:0] port_a_i,
  output logic [7:0] port_c_i
);
  // device wins where enabled; open-drain high releases the pad to the board
  assign port_a_i = (port_a_oe & port_a_o) | (~port_a_oe & ext_a);
  assign port_c_i = (port_c_oe & port_c_o) | (~port_c_oe & ext_c);
endmodule : pad_board_model

// ==== dv/port_pin_control_bench.sv ====
`timescale 1ns/100ps
// register and pad checks of the port pin block
module port_pin_control_bench;
  import port_pin_pkg::*;
  `define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
  // clock, reset and bus
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, rd;
  logic waitrequest;
  // straps and board levels
  logic osc_cfg = 1'b0;
  logic chan2_cfg = 1'b1;
  logic secondary_oscillator_on = 1'b0;
  logic [7:0] ext_a = 8'h00;
  logic [7:0] ext_c = 8'h00;
  logic [7:0] port_a_i, port_a_o, port_a_oe, port_c_i, port_c_o, port_c_oe;
  // pull-up latches, chosen so each group differs
  logic [7:0] d_lat = 8'h96;
  logic [7:0] e_lat = 8'h5a;
  logic [7:0] j_lat = 8'h3c;
  logic [7:0] pu_d, pu_e, pu_j;
  // rtc sources: bit2 source clock, bit1 seconds, bit0 alarm
  logic [2:0] rtc_in = 3'h0;
  logic rtc_pin, rtc_oe;
  // peripherals: chan1 val/act/tri, chan2 val/act/tri, spi val/act, uart val/act
  logic [9:0] per = 10'h000;
  // timer0, timer1, gate3, secondary clock, chan2 capture
  logic [4:0] tin;
  logic prev;
  int n;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;

  port_pin_control u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .osc_pin_claim_cfg(osc_cfg), .chan2_pin_assign_cfg(chan2_cfg),
    .secondary_oscillator(secondary_oscillator_on),
    .port_a_i(port_a_i), .port_a_o(port_a_o), .port_a_oe(port_a_oe),
    .port_c_i(port_c_i), .port_c_o(port_c_o), .port_c_oe(port_c_oe),
    .port_d_latch(d_lat), .port_e_latch(e_lat), .port_j_latch(j_lat),
    .group_d_pullup_en(pu_d), .group_e_pullup_en(pu_e), .group_j_pullup_en(pu_j),
    .rtc_src_clk(rtc_in[2]), .rtc_sec_clk(rtc_in[1]), .rtc_alarm(rtc_in[0]),
    .real_time_clock(rtc_pin), .real_time_clock_oe(rtc_oe),
    .chan1_pwm_out_a(per[0]), .chan1_act(per[1]), .chan1_shutdown_tri(per[2]),
    .chan2_pwm_out_a(per[3]), .chan2_act(per[4]), .chan2_shutdown_tri(per[5]),
    .spi_out(per[6]), .spi_act(per[7]), .uart_out(per[8]), .uart_act(per[9]),
    .timer_zero_clk_in(tin[0]), .timer_one_clk_in(tin[1]),
    .timer_three_gate_in(tin[2]), .secondary_digital_clk_in(tin[3]),
    .enh_capture_chan2(tin[4])
  );

  pad_board_model u_board (
    .port_a_o(port_a_o), .port_a_oe(port_a_oe), .port_c_o(port_c_o),
    .port_c_oe(port_c_oe), .ext_a(ext_a), .ext_c(ext_c),
    .port_a_i(port_a_i), .port_c_i(port_c_i)
  );

  // free-running system clock
  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end

  // hang guard: the whole sequence needs well under this many cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  // print the counts and the verdict, then stop
  task automatic give_verdict();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // one transfer; held until the rising edge that sees waitrequest low, data taken there
  task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    address <= a;
    writedata <= {24'h0, d};
    read <= ~wr;
    write <= wr;
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus_xfer

  // register write
  task automatic wrr(input logic [3:0] a, input logic [7:0] d);
    bus_xfer(1'b1, a, d);
  endtask : wrr

  // register read compared to an expected byte
  task automatic expect_reg(input logic [3:0] a, input logic [7:0] e);
    bus_xfer(1'b0, a, 8'h00);
    `CHK(rd, {24'h0, e})
  endtask : expect_reg

  // let registered pads follow, then look mid-cycle
  task automatic settle();
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : settle

  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    expect_reg(ADDR_PORT_A_DIR, DIR_RESET);
    expect_reg(ADDR_ANALOG_SEL, ANALOG_RESET);
    expect_reg(ADDR_PORT_C_DIR, DIR_RESET);
    expect_reg(ADDR_PAD_CONFIG, ZERO_BYTE);
    expect_reg(4'hf, ZERO_BYTE);
    `CHK(port_c_oe, ZERO_BYTE)
    // group pull-ups follow latches only with the group bit set
    wrr(ADDR_PAD_CONFIG, 8'hff);
    expect_reg(ADDR_PAD_CONFIG, PAD_CONFIG_MASK);
    settle();
    `CHK({pu_d, pu_e, pu_j}, {d_lat, e_lat, j_lat})
    wrr(ADDR_PAD_CONFIG, 8'h40);
    settle();
    `CHK({pu_d, pu_e, pu_j}, {8'h00, e_lat, 8'h00})
    // each select code routes exactly its own source
    wrr(ADDR_RTC_CTRL, 8'h01);
    for (int c = 0; c < 3; c++)
    begin
      wrr(ADDR_PAD_CONFIG, 8'(c << PAD_SEL_LO));
      rtc_in <= 3'(1 << c);
      settle();
      `CHK({rtc_oe, rtc_pin}, 2'b11)
      @(posedge clk_sys);
      rtc_in <= ~3'(1 << c);
      settle();
      `CHK(rtc_pin, 1'b0)
    end
    wrr(ADDR_PAD_CONFIG, 8'h06);
    settle();
    `CHK(rtc_pin, 1'b0)
    wrr(ADDR_RTC_CTRL, 8'h00);
    settle();
    `CHK({rtc_oe, rtc_pin}, 2'b00)
    // port a outputs drive latch despite analog select
    wrr(ADDR_PORT_A_LAT, 8'h5a);
    wrr(ADDR_PORT_A_DIR, 8'h00);
    settle();
    `CHK({port_a_oe, port_a_o}, 16'hff5a)
    `CHK(tin[2:0], 3'b001)
    expect_reg(ADDR_PORT_A_DIR, 8'h00);
    wrr(ADDR_PORT_A_PIN, 8'ha5);
    expect_reg(ADDR_PORT_A_LAT, 8'ha5);
    settle();
    `CHK(port_a_o, 8'ha5)
    `CHK(tin[2:0], 3'b110)
    // inputs: analog blocks all but the timer-zero pin
    wrr(ADDR_PORT_A_DIR, 8'hff);
    ext_a <= 8'hd3;
    settle();
    `CHK(port_a_oe, 8'h00)
    expect_reg(ADDR_PORT_A_PIN, 8'h10);
    `CHK(tin[2:0], 3'b001)
    wrr(ADDR_ANALOG_SEL, 8'h00);
    settle();
    expect_reg(ADDR_PORT_A_PIN, 8'hd3);
    // oscillator claim: bits 6 and 7 leave the port, pin 6 carries clock / 4
    osc_cfg <= 1'b1;
    settle();
    expect_reg(ADDR_PORT_A_PIN, 8'h13);
    `CHK(port_a_oe[7:6], 2'b01)
    n = 0;
    prev = port_a_o[6];
    repeat (8)
    begin
      @(negedge clk_sys);
      n += int'(port_a_o[6] !== prev);
      prev = port_a_o[6];
    end
    `CHK(n, 4)
    @(posedge clk_sys);
    osc_cfg <= 1'b0;
    // port c: peripherals beat the latch, open-drain releases highs
    wrr(ADDR_PORT_C_LAT, 8'h00);
    wrr(ADDR_PORT_C_DIR, 8'h00);
    settle();
    `CHK(port_c_oe, 8'hff)
    @(posedge clk_sys);
    per <= 10'h003;
    settle();
    `CHK({port_c_oe[CHAN1_BIT], port_c_o[CHAN1_BIT]}, 2'b11)
    wrr(ADDR_OPEN_DRAIN, 8'h01);
    settle();
    `CHK(port_c_oe[CHAN1_BIT], 1'b0)
    @(posedge clk_sys);
    per <= 10'h006;
    settle();
    `CHK(port_c_oe[CHAN1_BIT], 1'b0)
    @(posedge clk_sys);
    per <= 10'h3db;
    wrr(ADDR_OPEN_DRAIN, 8'h0f);
    settle();
    `CHK(port_c_oe, 8'h99)
    wrr(ADDR_OPEN_DRAIN, 8'h00);
    wrr(ADDR_PORT_C_DIR, 8'h80);
    settle();
    `CHK({port_c_oe, port_c_o}, 16'h7f66)
    expect_reg(ADDR_PORT_C_DIR, 8'h80);
    // port c inputs: secondary clock and channel-two capture
    wrr(ADDR_PORT_C_DIR, 8'hff);
    per <= 10'h000;
    ext_c <= 8'h03;
    settle();
    expect_reg(ADDR_PORT_C_PIN, 8'h03);
    `CHK(tin[4:3], 2'b11)
    secondary_oscillator_on <= 1'b1;
    chan2_cfg <= 1'b0;
    settle();
    `CHK(tin[4:3], 2'b00)
    // reset in mid-run restores inputs
    wrr(ADDR_PORT_C_DIR, 8'h00);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    expect_reg(ADDR_PORT_C_DIR, DIR_RESET);
    `CHK(port_c_oe, 8'h00)
    give_verdict();
  end
endmodule : port_pin_control_bench
